// ===== bench/rdb_top_tb.sv
// Purpose: Register, steering and receive sequence checks for the back end
// Assumes: Wishbone ack comes one cycle after a request; bit period cut to 16 clocks
// Notes:   The transmitter model supplies the samples; the stimulus is fixed
`default_nettype none
module rdb_top_tb
    import rdb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i, rst_i, cyc, stb, we, rx_en, tx_on, ack_o, ifo, dclk, rre, dat_b, d_prev;
    logic [7:0]  adr, lo, bws;
    logic [31:0] wdat, dat_o, r, fe;
    logic [23:0] car;
    logic signed [7:0] iq_i, iq_q;
    int          n_fail = 0, n_tests = 0, k;
    rdb_top i_dut (.clk_i, .rst_i, .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(4'hf), .dat_i(wdat), .dat_o, .ack_o, .rx_enable_i(rx_en), .packet_mode_i(1'b0),
        .i_sample_i(iq_i), .q_sample_i(iq_q), .image_filter_on_o(ifo), .lo_if_offset_o(lo),
        .bandwidth_sel_o(bws), .carrier_freq_o(car), .data_o(dat_b), .data_clock_out_o(dclk),
        .receiver_ready_event_o(rre));
    rdb_tx_model #(.BIT_CLKS(16)) i_tx (.clk_i, .rst_i, .tx_on_i(tx_on), .i_o(iq_i), .q_o(iq_q));
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    task automatic end_of_test;
        if (n_fail == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Holds the request until ack is seen at a rising edge, then releases it
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        {cyc, stb, we, adr, wdat} <= {2'h3, w, a, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        r = dat_o;
        {cyc, stb, we} <= 3'h0;
        @(posedge clk_i);
        if (n >= 20) begin
            n_fail++;
            end_of_test();
        end
    endtask : wb
    initial begin
        {rst_i, cyc, stb, we, rx_en, tx_on, adr, wdat} = {1'b1, 5'h0, 8'h0, 32'h0};
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, ADDR_BITRATE, 32'h0);
        chk(r, {16'h0, BITRATE_RST});
        wb(1'b0, ADDR_CARRIER, 32'h0);
        chk(r, {8'h0, CARRIER_RST});
        chk({8'h0, car}, {8'h0, CARRIER_RST});
        wb(1'b0, 8'hfc, 32'h0);
        chk(r, 32'h0);
        wb(1'b1, ADDR_BITRATE, 32'h10);
        wb(1'b1, ADDR_BW, 32'ha046);
        wb(1'b1, ADDR_MODUL, {30'h0, MOD_OOK});
        @(negedge clk_i);
        chk({31'h0, ifo}, 32'h1);
        chk({24'h0, lo}, 32'h23);
        chk({24'h0, bws}, 32'h46);
        wb(1'b1, ADDR_MODUL, {30'h0, MOD_FSK});
        @(negedge clk_i);
        chk({31'h0, ifo}, 32'h0);
        wb(1'b0, ADDR_STRENGTH, 32'h0);
        chk(r, 32'hff);
        {rx_en, tx_on} <= 2'h3;
        for (k = 0; k < 3000 && rre !== 1'b1; k++) @(negedge clk_i);
        chk({31'h0, rre}, 32'h1);
        if (k >= 3000) end_of_test();
        r = 32'h0;
        d_prev = dat_b;
        k = 0;
        // Recovered clock seen high and low; data flips once per preamble bit
        repeat (256) begin
            @(negedge clk_i);
            r = r | {30'h0, dclk === 1'b0, dclk === 1'b1};
            if (dat_b !== d_prev) k++;
            d_prev = dat_b;
        end
        chk(r, 32'h3);
        chk({31'h0, k >= 15 && k <= 17}, 32'h1);
        wb(1'b0, ADDR_STATUS, 32'h0);
        chk({31'h0, r[5]}, 32'h1);
        wb(1'b0, ADDR_STRENGTH, 32'h0);
        chk({31'h0, r < {24'h0, STR_THR_RST}}, 32'h1);
        wb(1'b1, ADDR_CORR_CTL, 32'h1);
        r = 32'h0;
        for (k = 0; k < 200 && r[CC_DONE] !== 1'b1; k++) wb(1'b0, ADDR_CORR_CTL, 32'h0);
        chk({30'h0, r[CC_DONE], r[CC_START]}, 32'h2);
        if (k >= 200) end_of_test();
        wb(1'b0, ADDR_FERR, 32'h0);
        fe = {8'h0, 24'(CARRIER_RST - {{8{r[15]}}, r[15:0]})};
        wb(1'b0, ADDR_CARRIER, 32'h0);
        chk(r, fe);
        chk({8'h0, car}, fe);
        wb(1'b1, ADDR_CORR_CTL, 32'h2);
        wb(1'b0, ADDR_CORR_CTL, 32'h0);
        chk({31'h0, r[CC_DONE]}, 32'h0);
        end_of_test();
    end
endmodule : rdb_top_tb
`default_nettype wire

// ===== bench/rdb_tx_model.sv
// Purpose: Far-end transmitter model sending an alternating preamble as I/Q samples
// Assumes: The bit period in clocks matches the receiver's programmed bit rate
// Notes:   When off, both rails sit at zero, as with no carrier present
`default_nettype none
module rdb_tx_model #(
    parameter int BIT_CLKS = 16
) (
    // Clock, reset and enable
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         tx_on_i,
    // Baseband samples
    output logic signed [7:0] i_o,
    output logic signed [7:0] q_o
);
    logic [15:0] cnt_q;
    logic        bit_q;
    logic [7:0]  ramp;
    always_ff @(posedge clk_i) begin
        if (rst_i || !tx_on_i) begin
            cnt_q <= 16'h0;
            bit_q <= 1'b0;
        end else if (cnt_q == 16'(BIT_CLKS - 1)) begin
            cnt_q <= 16'h0;
            bit_q <= ~bit_q;
        end else begin
            cnt_q <= cnt_q + 16'h1;
        end
    end
    // Same rate as the receiver, so far inside the rate tolerance
    assign i_o = tx_on_i ? 8'sh64 : 8'sh00;
    // Phase ramps up through a one and down through a zero; the step assumes 16 clocks a bit
    assign ramp = {1'b0, cnt_q[3:0], 3'h0};
    assign q_o = !tx_on_i ? 8'sh00 : (bit_q ? 8'(8'hc0 + ramp) : 8'(8'h40 - ramp));
endmodule : rdb_tx_model
`default_nettype wire

// ===== verilog/rdb_pkg.sv
// Purpose: Shared constants and carrier types for the receiver digital back end
// Assumes: 10 MHz core clock, classic Wishbone register access
// Notes:   Register offsets are byte addresses of aligned 32-bit words
`default_nettype none
package rdb_pkg;
    localparam logic [7:0]  ADDR_MODUL     = 8'h00;
    localparam logic [7:0]  ADDR_BITRATE   = 8'h04;
    localparam logic [7:0]  ADDR_BW        = 8'h08;
    localparam logic [7:0]  ADDR_STR_THR   = 8'h0c;
    localparam logic [7:0]  ADDR_PEAK      = 8'h10;
    localparam logic [7:0]  ADDR_FLOOR     = 8'h14;
    localparam logic [7:0]  ADDR_CORR_CTL  = 8'h18;
    localparam logic [7:0]  ADDR_FERR      = 8'h1c;
    localparam logic [7:0]  ADDR_CORR_VAL  = 8'h20;
    localparam logic [7:0]  ADDR_CARRIER   = 8'h24;
    localparam logic [7:0]  ADDR_STRENGTH  = 8'h28;
    localparam logic [7:0]  ADDR_STATUS    = 8'h2c;
    // Modulation field in data_modulation_reg bits [1:0]
    localparam logic [1:0]  MOD_FSK        = 2'h0;
    localparam logic [1:0]  MOD_OOK        = 2'h1;
    // Threshold types in onoff_peak_reg bits [7:6]
    localparam logic [1:0]  THR_FIXED      = 2'h0;
    localparam logic [1:0]  THR_PEAK       = 2'h1;
    localparam logic [1:0]  THR_AVG        = 2'h2;
    localparam int          PEAK_TYPE_LSB  = 6;
    localparam int          STEP_LSB       = 3;
    // Correction control bit positions
    localparam int          CC_START       = 0;
    localparam int          CC_DONE        = 1;
    localparam int          CC_AUTO_CLR    = 2;
    localparam int          CC_AUTO        = 3;
    localparam int          CC_FEI_START   = 4;
    localparam int          CC_FEI_DONE    = 5;
    // Reset values
    localparam logic [15:0] BITRATE_RST    = 16'h1a0b;
    localparam logic [7:0]  STR_THR_RST    = 8'he4;
    localparam logic [7:0]  PEAK_RST       = 8'h40;
    localparam logic [7:0]  FLOOR_RST      = 8'h06;
    localparam logic [7:0]  BW_RST         = 8'h8b;
    localparam logic [23:0] CARRIER_RST    = 24'he4c000;
    // Weakest reading, so the receiver cannot leave its wait state on reset alone
    localparam logic [7:0]  STRENGTH_RST   = 8'hff;
    // Signal strength is -value/2 dBm: 0.5 dB per step, 6 dB is 12 steps
    localparam logic [7:0]  SIX_DB_STEPS   = 8'h0c;
    localparam int          STRENGTH_BITS  = 2;
    localparam int          FERR_BITS      = 4;
    localparam int          SYNC_LOCK_BITS = 12;

    typedef enum logic [1:0] {RDB_IDLE, RDB_WAIT, RDB_CORR, RDB_DEMOD} rdb_rx_st_t;

    typedef struct packed {
        logic       data;
        logic       dclk;
    } rdb_out_t;
endpackage : rdb_pkg
`default_nettype wire

// ===== verilog/rdb_top.sv
// Purpose: Receiver demodulation, bit sync, strength and frequency correction
// Assumes: One I/Q sample per clock, I and Q samples signed 8 bit
// Notes:   Carrier register is the live operating frequency; correction edits it
`default_nettype none
// Functional notes
// - In on-off mode the low IF is half the channel bandwidth, LO offset.
// - Image filter is bypassed whenever modulation select is FSK (00).
// - Strength has 0.5 dB steps; one acquisition takes two bit periods.
// - Strength value reads as 0xff until it drops below the strength threshold.
// - Vector stage yields phase and amplitude from the I/Q samples.
// - FSK decisions feed the bit synchronizer for the continuous stream.
// - On-off bit decided by strength versus one of three threshold modes.
// - Peak mode threshold is tracked peak minus six decibels.
// - On zero or no signal, peak drops one step per decay period.
// - Decaying peak stops at the floor threshold and holds.
// - Fixed mode uses the floor; average mode uses a running mean.
// - Continuous mode drives a recovered clean data clock; can be disabled.
// - Sync always on in packet mode; rate from high and low rate fields.
// - Error indicator measures over four bits, stores signed two's complement.
// - Completed correction value is subtracted from the carrier register.
// - Auto correction at receiver enable if set, else on software start bit.
// - Auto-clear set clears old correction first, else starts from it.
// - During correction the separate correction bandwidth is applied.
// - Receiver waits until strength exceeds threshold before demodulating.
module rdb_top
    import rdb_pkg::*;
#(
    parameter int SAMPLE_W = 8
) (
    // Clock and reset
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    // Wishbone slave
    input  wire logic                cyc_i,
    input  wire logic                stb_i,
    input  wire logic                we_i,
    input  wire logic [7:0]          adr_i,
    input  wire logic [3:0]          sel_i,
    input  wire logic [31:0]         dat_i,
    output logic      [31:0]         dat_o,
    output logic                     ack_o,
    // Receiver control and samples
    input  wire logic                rx_enable_i,
    input  wire logic                packet_mode_i,
    input  wire logic signed [SAMPLE_W-1:0] i_sample_i,
    input  wire logic signed [SAMPLE_W-1:0] q_sample_i,
    // Front end steering
    output logic                     image_filter_on_o,
    output logic      [7:0]          lo_if_offset_o,
    output logic      [7:0]          bandwidth_sel_o,
    output logic      [23:0]         carrier_freq_o,
    // Data to processor
    output logic                     data_o,
    output logic                     data_clock_out_o,
    output logic                     receiver_ready_event_o
);
    typedef struct packed {
        logic [31:0]           rdat;
        logic                  ack;
        logic [1:0]            modulation_select;
        logic                  sync_off;
        logic [15:0]           bit_rate;
        logic [7:0]            channel_bandwidth;
        logic [7:0]            corr_bandwidth;
        logic [7:0]            signal_strength_threshold;
        logic [7:0]            onoff_peak_reg;
        logic [7:0]            floor_threshold;
        logic                  auto_correction_enable;
        logic                  auto_clear_enable;
        logic                  correction_start;
        logic                  corr_done;
        logic                  fei_start;
        logic                  fei_done;
        logic signed [15:0]    freq_error_value;
        logic signed [15:0]    freq_correction_value;
        logic [23:0]           carrier;
        logic [15:0]           bit_cnt;
        logic                  bit_tick;
        logic [7:0]            strength;
        logic [9:0]            str_acc;
        logic [1:0]            str_bits;
        logic [7:0]            peak;
        logic [7:0]            decay_cnt;
        logic [11:0]           avg;
        logic signed [SAMPLE_W-1:0] prev_phase;
        logic signed [15:0]    ferr_acc;
        logic [2:0]            ferr_bits;
        logic                  ferr_run;
        logic                  ferr_auto;
        logic                  raw_bit;
        logic                  prev_raw;
        logic [15:0]           sync_phase;
        logic [3:0]            lock_cnt;
        logic                  rx_en_q;
        rdb_rx_st_t            st;
        rdb_out_t              out;
        logic                  ready_pulse;
        logic                  img_on;
        logic [7:0]            bw_sel;
        logic [7:0]            if_off;
    } rdb_state_t;

    rdb_state_t s_q, s_d;

    logic [7:0]          mag;
    logic [7:0]          thr;
    logic signed [SAMPLE_W-1:0] phase;
    logic [7:0]          str_view;
    logic                wr;
    logic                rd;
    logic [3:0]          decay_sel;

    // Crude vector extraction: (|I|+|Q|)/2 magnitude, phase proxy is Q folded by the sign of I
    always_comb begin
        logic [SAMPLE_W-1:0] ai;
        logic [SAMPLE_W-1:0] aq;
        ai = i_sample_i[SAMPLE_W-1] ? SAMPLE_W'(-i_sample_i) : SAMPLE_W'(i_sample_i);
        aq = q_sample_i[SAMPLE_W-1] ? SAMPLE_W'(-q_sample_i) : SAMPLE_W'(q_sample_i);
        mag = 8'(({1'b0, ai} + {1'b0, aq}) >> 1);
        phase = i_sample_i[SAMPLE_W-1] ? -q_sample_i : q_sample_i;
    end

    assign wr = cyc_i && stb_i && we_i && !s_q.ack;
    assign rd = cyc_i && stb_i && !we_i && !s_q.ack;
    assign decay_sel = {1'b0, s_q.onoff_peak_reg[2:0]};
    // Strength hidden until threshold crossed; lower value is a stronger signal
    assign str_view = (s_q.strength < s_q.signal_strength_threshold) ? s_q.strength
                                                                      : 8'hff;

    // Comparison threshold by mode; strength counts up with power here
    always_comb begin
        case (s_q.onoff_peak_reg[PEAK_TYPE_LSB +: 2])
            THR_PEAK: thr = (s_q.peak > s_q.floor_threshold + SIX_DB_STEPS)
                            ? 8'(s_q.peak - SIX_DB_STEPS) : s_q.floor_threshold;
            THR_AVG:  thr = s_q.avg[11:4];
            default:  thr = s_q.floor_threshold;
        endcase
    end

    always_comb begin
        logic corr_set;
        logic fei_set;
        corr_set = 1'b0;
        fei_set = 1'b0;
        s_d = s_q;
        s_d.ack = cyc_i && stb_i && !s_q.ack;
        s_d.ready_pulse = 1'b0;
        s_d.rx_en_q = rx_enable_i;
        // Bit period tick from the concatenated rate fields
        s_d.bit_tick = 1'b0;
        if (s_q.bit_cnt >= s_q.bit_rate - 16'h0001) begin
            s_d.bit_cnt = 16'h0000;
            s_d.bit_tick = 1'b1;
        end else begin
            s_d.bit_cnt = 16'(s_q.bit_cnt + 16'h0001);
        end
        // Strength: running mean of magnitude, taken once every two bit periods, shown as 0.5 dB steps
        s_d.str_acc = 10'(s_q.str_acc + {2'h0, mag} - {2'h0, s_q.str_acc[9:2]});
        if (s_q.bit_tick) begin
            s_d.str_bits = 2'(s_q.str_bits + 2'h1);
            if (s_q.str_bits == 2'(STRENGTH_BITS - 1)) begin
                s_d.strength = 8'hff - s_q.str_acc[9:2];
                s_d.str_bits = 2'h0;
            end
        end
        s_d.avg = 12'(s_q.avg + {4'h0, mag} - {4'h0, s_q.avg[11:4]});
        // Peak tracking with stepwise decay held at the floor
        if (mag > s_q.peak) begin
            s_d.peak = mag;
            s_d.decay_cnt = 8'h00;
        end else if (s_q.decay_cnt >= 8'(8'h01 << decay_sel)) begin
            s_d.decay_cnt = 8'h00;
            if (s_q.peak > s_q.floor_threshold + {5'h0, s_q.onoff_peak_reg[5:3]})
                s_d.peak = 8'(s_q.peak - {5'h0, s_q.onoff_peak_reg[5:3]} - 8'h01);
            else
                s_d.peak = s_q.floor_threshold;
        end else begin
            s_d.decay_cnt = 8'(s_q.decay_cnt + 8'h01);
        end
        // Demodulation decision
        if (s_q.modulation_select == MOD_FSK)
            s_d.raw_bit = (phase - s_q.prev_phase) >= 0;
        else
            s_d.raw_bit = mag > thr;
        s_d.prev_phase = phase;
        s_d.prev_raw = s_q.raw_bit;
        // Bit synchronizer: realign mid-bit on every transition
        if (s_q.raw_bit != s_q.prev_raw) begin
            s_d.sync_phase = 16'(s_q.bit_rate >> 1);
            if (s_q.lock_cnt != 4'(SYNC_LOCK_BITS)) s_d.lock_cnt = 4'(s_q.lock_cnt + 4'h1);
        end else if (s_q.sync_phase == 16'h0000) begin
            s_d.sync_phase = 16'(s_q.bit_rate - 16'h0001);
        end else begin
            s_d.sync_phase = 16'(s_q.sync_phase - 16'h0001);
        end
        if (s_q.st != RDB_DEMOD) begin
            s_d.out = '0;
        end else if (!s_q.sync_off || packet_mode_i) begin
            if (s_q.sync_phase == 16'h0000) s_d.out.data = s_q.raw_bit;
            s_d.out.dclk = s_q.sync_phase < 16'(s_q.bit_rate >> 1);
        end else begin
            s_d.out.data = s_q.raw_bit;
            s_d.out.dclk = 1'b0;
        end
        // Frequency error over four bit periods
        if (s_q.ferr_run) begin
            s_d.ferr_acc = 16'(s_q.ferr_acc + 16'(phase - s_q.prev_phase));
            if (s_q.bit_tick) begin
                s_d.ferr_bits = 3'(s_q.ferr_bits + 3'h1);
                if (s_q.ferr_bits == 3'(FERR_BITS - 1)) begin
                    s_d.ferr_run = 1'b0;
                    s_d.freq_error_value = s_q.ferr_acc;
                    s_d.fei_start = 1'b0;
                    s_d.fei_done = 1'b1;
                    fei_set = 1'b1;
                    if (s_q.st == RDB_CORR) begin
                        s_d.freq_correction_value = 16'(s_q.freq_correction_value + s_q.ferr_acc);
                        s_d.carrier = 24'(s_q.carrier - {{8{s_q.ferr_acc[15]}}, s_q.ferr_acc});
                        s_d.st = RDB_DEMOD;
                        s_d.ready_pulse = 1'b1;
                        if (!s_q.ferr_auto) begin
                            s_d.correction_start = 1'b0;
                            s_d.corr_done = 1'b1;
                            corr_set = 1'b1;
                        end
                    end
                end
            end
        end
        // Receiver sequence
        case (s_q.st)
            RDB_IDLE: if (rx_enable_i && !s_q.rx_en_q) s_d.st = RDB_WAIT;
            RDB_WAIT: if (s_q.strength < s_q.signal_strength_threshold) begin
                if (s_q.auto_correction_enable) begin
                    s_d.st = RDB_CORR;
                    s_d.ferr_auto = 1'b1;
                    s_d.ferr_run = 1'b1;
                    s_d.ferr_acc = '0;
                    s_d.ferr_bits = '0;
                    if (s_q.auto_clear_enable) begin
                        s_d.carrier = 24'(s_q.carrier +
                            {{8{s_q.freq_correction_value[15]}}, s_q.freq_correction_value});
                        s_d.freq_correction_value = '0;
                    end
                end else begin
                    s_d.st = RDB_DEMOD;
                    s_d.ready_pulse = 1'b1;
                    s_d.lock_cnt = '0;
                end
            end
            RDB_CORR, RDB_DEMOD: begin
                if (s_q.correction_start && !s_q.ferr_run && !s_q.auto_correction_enable) begin
                    s_d.st = RDB_CORR;
                    s_d.ferr_auto = 1'b0;
                    s_d.ferr_run = 1'b1;
                    s_d.ferr_acc = '0;
                    s_d.ferr_bits = '0;
                end
            end
            default: s_d.st = RDB_IDLE;
        endcase
        if (!rx_enable_i) begin
            s_d.st = RDB_IDLE;
            s_d.ferr_run = 1'b0;
        end
        if (s_q.fei_start && !s_q.ferr_run && s_q.st == RDB_DEMOD) begin
            s_d.ferr_auto = 1'b1;
            s_d.ferr_run = 1'b1;
            s_d.ferr_acc = '0;
            s_d.ferr_bits = '0;
        end
        // Front end steering
        s_d.img_on = s_q.modulation_select != MOD_FSK;
        s_d.if_off = (s_q.modulation_select == MOD_OOK) ? 8'(s_q.channel_bandwidth >> 1)
                                                         : 8'h00;
        s_d.bw_sel = (s_q.st == RDB_CORR || s_q.st == RDB_WAIT && s_q.auto_correction_enable)
                     ? s_q.corr_bandwidth : s_q.channel_bandwidth;
        // Register writes; hardware set of done flags wins over software clear
        if (wr && sel_i[0]) begin
            case (adr_i)
                ADDR_MODUL:    begin
                    s_d.modulation_select = dat_i[1:0];
                    s_d.sync_off = dat_i[2];
                end
                ADDR_BITRATE:  s_d.bit_rate = dat_i[15:0];
                ADDR_BW:       begin
                    s_d.channel_bandwidth = dat_i[7:0];
                    s_d.corr_bandwidth = dat_i[15:8];
                end
                ADDR_STR_THR:  s_d.signal_strength_threshold = dat_i[7:0];
                ADDR_PEAK:     s_d.onoff_peak_reg = dat_i[7:0];
                ADDR_FLOOR:    s_d.floor_threshold = dat_i[7:0];
                ADDR_CORR_CTL: begin
                    // A finishing run has already cleared its start bit; do not revive it
                    s_d.correction_start = dat_i[CC_START] | s_d.correction_start;
                    s_d.auto_clear_enable = dat_i[CC_AUTO_CLR];
                    s_d.auto_correction_enable = dat_i[CC_AUTO];
                    s_d.fei_start = dat_i[CC_FEI_START] | s_d.fei_start;
                    if (dat_i[CC_DONE] && !corr_set) s_d.corr_done = 1'b0;
                    if (dat_i[CC_FEI_DONE] && !fei_set) s_d.fei_done = 1'b0;
                end
                ADDR_CARRIER:  s_d.carrier = dat_i[23:0];
                default: ;
            endcase
        end
        s_d.rdat = 32'h0;
        if (rd) begin
            case (adr_i)
                ADDR_MODUL:    s_d.rdat = {29'h0, s_q.sync_off, s_q.modulation_select};
                ADDR_BITRATE:  s_d.rdat = {16'h0, s_q.bit_rate};
                ADDR_BW:       s_d.rdat = {16'h0, s_q.corr_bandwidth, s_q.channel_bandwidth};
                ADDR_STR_THR:  s_d.rdat = {24'h0, s_q.signal_strength_threshold};
                ADDR_PEAK:     s_d.rdat = {24'h0, s_q.onoff_peak_reg};
                ADDR_FLOOR:    s_d.rdat = {24'h0, s_q.floor_threshold};
                ADDR_CORR_CTL: s_d.rdat = {26'h0, s_q.fei_done, s_q.fei_start,
                    s_q.auto_correction_enable, s_q.auto_clear_enable,
                    s_q.corr_done, s_q.correction_start};
                ADDR_FERR:     s_d.rdat = {16'h0, s_q.freq_error_value};
                ADDR_CORR_VAL: s_d.rdat = {16'h0, s_q.freq_correction_value};
                ADDR_CARRIER:  s_d.rdat = {8'h0, s_q.carrier};
                ADDR_STRENGTH: s_d.rdat = {24'h0, str_view};
                ADDR_STATUS:   s_d.rdat = {26'h0, s_q.lock_cnt == 4'(SYNC_LOCK_BITS),
                    s_q.ferr_run, 2'h0, 2'(s_q.st)};
                default:       s_d.rdat = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
            s_q.bit_rate <= BITRATE_RST;
            s_q.signal_strength_threshold <= STR_THR_RST;
            s_q.onoff_peak_reg <= PEAK_RST;
            s_q.floor_threshold <= FLOOR_RST;
            s_q.channel_bandwidth <= BW_RST;
            s_q.corr_bandwidth <= BW_RST;
            s_q.carrier <= CARRIER_RST;
            s_q.strength <= STRENGTH_RST;
            s_q.st <= RDB_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign dat_o = s_q.rdat;
    assign ack_o = s_q.ack;
    assign image_filter_on_o = s_q.img_on;
    assign lo_if_offset_o = s_q.if_off;
    assign bandwidth_sel_o = s_q.bw_sel;
    assign carrier_freq_o = s_q.carrier;
    assign data_o = s_q.out.data;
    assign data_clock_out_o = s_q.out.dclk;
    assign receiver_ready_event_o = s_q.ready_pulse;

    a_fsk_bypass: assert property (@(posedge clk_i) disable iff (rst_i)
        s_q.modulation_select == MOD_FSK |=> !image_filter_on_o)
        else $error("image filter not bypassed in FSK");
    a_wait_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        s_q.st == RDB_WAIT && s_q.strength >= s_q.signal_strength_threshold && rx_enable_i
        |=> s_q.st == RDB_WAIT)
        else $error("left wait below strength threshold");
    a_peak_floor: assert property (@(posedge clk_i) disable iff (rst_i)
        s_q.peak >= s_q.floor_threshold && mag <= s_q.peak |=> s_q.peak >= $past(s_q.floor_threshold))
        else $error("peak fell below floor");
    a_fixed_thr: assert property (@(posedge clk_i) disable iff (rst_i)
        s_q.onoff_peak_reg[7:6] == THR_FIXED |-> thr == s_q.floor_threshold)
        else $error("fixed threshold wrong");
    a_str_hidden: assert property (@(posedge clk_i) disable iff (rst_i)
        rd && adr_i == ADDR_STRENGTH && s_q.strength >= s_q.signal_strength_threshold
        |=> dat_o == 32'h000000ff)
        else $error("strength readable below threshold");
    a_corr_sub: assert property (@(posedge clk_i) disable iff (rst_i)
        s_q.ready_pulse && $past(s_q.st) == RDB_CORR && !$past(wr)
        |-> carrier_freq_o == 24'($past(s_q.carrier) - {{8{$past(s_q.ferr_acc[15])}}, $past(s_q.ferr_acc)}))
        else $error("carrier not corrected");
    a_ook_if: assert property (@(posedge clk_i) disable iff (rst_i)
        s_q.modulation_select == MOD_OOK |=> lo_if_offset_o == 8'($past(s_q.channel_bandwidth) >> 1))
        else $error("IF offset wrong");
    a_corr_bw: assert property (@(posedge clk_i) disable iff (rst_i)
        s_q.st == RDB_CORR |=> bandwidth_sel_o == $past(s_q.corr_bandwidth))
        else $error("correction bandwidth not applied");
    c_demod: cover property (@(posedge clk_i) s_q.st == RDB_DEMOD);
    c_corr: cover property (@(posedge clk_i) s_q.st == RDB_CORR ##1 s_q.st == RDB_DEMOD);
    c_lock: cover property (@(posedge clk_i) s_q.lock_cnt == 4'(SYNC_LOCK_BITS));
endmodule : rdb_top
`default_nettype wire
